// File: hw/sss_defines.svh
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SSS_CLK_PERIOD_NS 4
`define SSS_SW_PER_250_NS 4000
`define SSS_SW_PER_500_NS 2000
`define SSS_SW_CYC_250 (`SSS_SW_PER_250_NS / `SSS_CLK_PERIOD_NS)
`define SSS_SW_CYC_500 (`SSS_SW_PER_500_NS / `SSS_CLK_PERIOD_NS)
`define SSS_SS_STEPS 32
`define SSS_SS_TOTAL_250 1024
`define SSS_SS_TOTAL_500 2048
`define SSS_SS_STEP_250 (`SSS_SS_TOTAL_250 / `SSS_SS_STEPS)
`define SSS_SS_STEP_500 (`SSS_SS_TOTAL_500 / `SSS_SS_STEPS)
`define SSS_OC_FILT_NS 50000
`define SSS_OC_FILT_CYC ((`SSS_OC_FILT_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS)
`define SSS_FAULT_TICKS_DEF 256
`define SSS_RST_TICKS_DEF 512

// ----------------------------------------
// register map
// ----------------------------------------
`define SSS_OFS_CTRL 12'h000
`define SSS_OFS_STAT 12'h004
`define SSS_OFS_REF_LO 12'h008
`define SSS_OFS_REF_HI 12'h00c
`define SSS_CTRL_RST 32'h0000_0003
`define SSS_CTRL_UV_EN 0
`define SSS_CTRL_OC_EN 1
`define SSS_STAT_FAULT 0
`define SSS_STAT_THERM 1
`define SSS_STAT_RST_OPEN 2
`define SSS_STAT_RATE 3
`define SSS_STAT_RUN 4
`define SSS_STAT_EN_LSB 8
`define SSS_STAT_DONE_LSB 16

`endif

// File: hw/sss_pkg.sv
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_RS_HOLD = 2'b00,
        SSS_RS_TIME = 2'b01,
        SSS_RS_OPEN = 2'b10
    } sss_rst_state_t;
    typedef logic [5:0] sss_code_t;
endpackage : sss_pkg

// File: hw/sss_ramp.sv
`include "sss_defines.svh"

module sss_ramp #(
    parameter bit NEG = 1'b0
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_b_i, // async reset, active low
    sss_ramp_if.ramp bus // ramp control and result
);
    localparam logic [6:0] STEP_LO = 7'(`SSS_SS_STEP_250);
    localparam logic [6:0] STEP_HI = 7'(`SSS_SS_STEP_500);
    localparam sss_pkg::sss_code_t STEPS = 6'(`SSS_SS_STEPS);

    logic [6:0] sub_ff;
    sss_pkg::sss_code_t cnt_ff;
    logic [6:0] nxt_sub;
    sss_pkg::sss_code_t nxt_cnt;

    wire [6:0] step_len = bus.rate_hi ? STEP_HI : STEP_LO;
    wire at_top = (cnt_ff == STEPS);
    wire step_end = bus.sw_tick && (sub_ff == step_len - 7'd1);

    // disabled ramp sits at its start value, so every enable restarts it
    assign nxt_sub = !bus.run || at_top ? 7'd0 : (step_end ? 7'd0 : sub_ff + 7'(bus.sw_tick));
    assign nxt_cnt = !bus.run ? 6'd0 : ((step_end && !at_top) ? cnt_ff + 6'd1 : cnt_ff);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sub_ff <= 7'd0;
            cnt_ff <= 6'd0;
        end else begin
            sub_ff <= nxt_sub;
            cnt_ff <= nxt_cnt;
        end
    end

    // negative rail counts down from the logic supply level to its floor
    assign bus.code = NEG ? STEPS - cnt_ff : cnt_ff;
    assign bus.done = at_top;
endmodule : sss_ramp

// File: hw/sss_ramp_if.sv
interface sss_ramp_if;
    logic run;
    logic sw_tick;
    logic rate_hi;
    sss_pkg::sss_code_t code;
    logic done;
    modport ctl (output run, output sw_tick, output rate_hi, input code, input done);
    modport ramp (input run, input sw_tick, input rate_hi, output code, output done);
endinterface : sss_ramp_if

// File: hw/sss_sync.sv
module sss_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic [W-1:0] async_i, // pin levels
    output logic [W-1:0] sync_o // filtered levels
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            wire agree = (s2_ff == s3_ff);
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    out_ff <= 1'b0;
                end else begin
                    s1_ff <= async_i[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    out_ff <= agree ? s3_ff : out_ff;
                end
            end
            assign sync_o[g] = out_ff;
        end
    endgenerate
endmodule : sss_sync

// File: hw/sss_top.sv
`include "sss_defines.svh"

// Functional notes
// - each regulator restarts its reference ramp whenever it becomes enabled
// - positive references rise from zero to full reference in 32 steps
// - negative reference falls from logic supply level to floor in 32 steps
// - ramp lasts 1024 switching cycles at 250kHz, 2048 at 500kHz
// - rate select high picks 500kHz, low picks 250kHz
// - supervisor reset driven low while monitor input is below threshold
// - reset also low during lockout, enable low, or any latch set
// - reset released only after monitor stays good for full timeout
// - supervisor reset output feeds only the status register, no regulator logic
// - after ramp done, low output starts the fault timer
// - low output lasting the full timer sets fault latch, disables regulators
// - fault latch keeps the internal logic supply running
// - rising sequence or enable edge clears fault latch once condition gone
// - over-temperature sets thermal latch at once, shuts everything down
// - thermal latch cleared only by power cycle, not enable or sequence
// - overcurrent sets the shared fault latch, disabling all regulators
// - overcurrent events shorter than 50us never set the latch
// - tripped valley limit during low-side conduction blocks next high-side pulse
// - step-down starts only with lockout off, enable high, latches clear
// - first logic linear regulator starts after step-down ramp completes
// - lockout release clears both fault and thermal latches
module sss_top #(
    parameter int FAULT_TICKS = `SSS_FAULT_TICKS_DEF,
    parameter int RST_TICKS = `SSS_RST_TICKS_DEF,
    parameter int OC_FILT_CYC = `SSS_OC_FILT_CYC,
    parameter int NREG = 6
) (
    input wire logic clk_sys_i, // 250 MHz system clock
    input wire logic rst_b_i, // async reset, supply lockout, active low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb write
    input wire logic [11:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error
    input wire logic en_i, // enable comparator
    input wire logic sequence_control_i, // sequence control input
    input wire logic switching_rate_select_i, // high 500kHz, low 250kHz
    input wire logic reset_monitor_input_i, // monitor above trip threshold
    input wire logic over_temp_i, // junction over temperature
    input wire logic over_current_i, // sense above overcurrent threshold
    input wire logic [5:0] out_low_i, // output below 90%, buck, lr1..lr5
    input wire logic [3:0] onl_reached_i, // on-threshold reached, lr2..lr5
    input wire logic ls_conduct_i, // low-side conduction interval
    input wire logic valley_trip_i, // valley current-limit comparator
    output logic buck_en_o, // step-down enable
    output logic [4:0] linear_regulator_channel_en_o, // lr1..lr5 enable
    output logic internal_logic_supply_en_o, // logic supply enable
    output logic onl_source_o, // on-pin current sources active
    output logic [35:0] ss_code_o, // ramp codes, 6 bits per regulator
    output logic hs_inhibit_o, // block next high-side on-time
    output logic sup_rst_o, // open-drain reset level
    output logic sup_rst_oe_b_o // low while reset pin is pulled low
);
    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    localparam int NPIN = 18;
    logic [NPIN-1:0] pin_s;

    sss_sync #(.W(NPIN)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i({valley_trip_i, ls_conduct_i, onl_reached_i, out_low_i, over_current_i,
                  over_temp_i, reset_monitor_input_i, switching_rate_select_i,
                  sequence_control_i, en_i}),
        .sync_o(pin_s)
    );

    wire en_s = pin_s[0];
    wire seq_s = pin_s[1];
    wire rate_s = pin_s[2];
    wire mon_s = pin_s[3];
    wire ot_s = pin_s[4];
    wire oc_s = pin_s[5];
    wire [5:0] low_s = pin_s[11:6];
    wire [3:0] onl_s = pin_s[15:12];
    wire ls_s = pin_s[16];
    wire valley_s = pin_s[17];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] ctrl_ff;
    logic fault_ff;
    logic therm_ff;
    logic en_d_ff;
    logic seq_d_ff;
    logic [9:0] sw_div_ff;
    logic sw_tick_ff;
    logic [15:0] uv_cnt_ff;
    logic [15:0] oc_cnt_ff;
    logic [15:0] rst_cnt_ff;
    sss_pkg::sss_rst_state_t rst_st_ff;
    logic rst_oe_b_ff;
    logic hs_inh_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    // ----------------------------------------
    // switching clock tick
    // ----------------------------------------
    localparam logic [9:0] DIV_250 = 10'(`SSS_SW_CYC_250);
    localparam logic [9:0] DIV_500 = 10'(`SSS_SW_CYC_500);

    wire [9:0] div_len = rate_s ? DIV_500 : DIV_250;
    wire div_end = (sw_div_ff >= div_len - 10'd1);
    wire [9:0] nxt_sw_div = div_end ? 10'd0 : sw_div_ff + 10'd1;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_div_ff <= 10'd0;
            sw_tick_ff <= 1'b0;
        end else begin
            sw_div_ff <= nxt_sw_div;
            sw_tick_ff <= div_end;
        end
    end

    // ----------------------------------------
    // enables and ramps
    // ----------------------------------------
    // lockout is the reset, so it never reaches this point active
    wire buck_run = en_s && !fault_ff && !therm_ff;
    logic [NREG-1:0] reg_run;
    logic [NREG-1:0] reg_done;

    sss_ramp_if rif[NREG]();

    assign reg_run[0] = buck_run;
    assign reg_run[1] = buck_run && reg_done[0];
    assign reg_run[5:2] = {4{buck_run}} & onl_s;

    genvar r;
    generate
        for (r = 0; r < NREG; r++) begin : g_reg
            assign rif[r].run = reg_run[r];
            assign rif[r].sw_tick = sw_tick_ff;
            assign rif[r].rate_hi = rate_s;
            assign reg_done[r] = rif[r].done;
            assign ss_code_o[6*r +: 6] = rif[r].code;
            // last channel is the negative rail
            sss_ramp #(.NEG(r == NREG - 1)) u_ramp (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .bus(rif[r].ramp)
            );
        end
    endgenerate

    assign buck_en_o = reg_run[0];
    assign linear_regulator_channel_en_o = reg_run[5:1];
    assign internal_logic_supply_en_o = !therm_ff;
    assign onl_source_o = buck_run && seq_s;

    // ----------------------------------------
    // undervoltage timer
    // ----------------------------------------
    localparam logic [15:0] FAULT_LEN = 16'(FAULT_TICKS);

    // only regulators that finished their ramp are watched
    wire uv_cond = ctrl_ff[`SSS_CTRL_UV_EN] && |(reg_run & reg_done & low_s);
    wire uv_hit = uv_cond && sw_tick_ff && (uv_cnt_ff == FAULT_LEN - 16'd1);
    wire [15:0] nxt_uv_cnt = !uv_cond ? 16'd0 : (uv_cnt_ff + 16'(sw_tick_ff && !uv_hit));

    // ----------------------------------------
    // overcurrent filter
    // ----------------------------------------
    localparam logic [15:0] OC_LEN = 16'(OC_FILT_CYC);

    // a dip below threshold restarts the count, so short bursts never latch
    wire oc_cond = ctrl_ff[`SSS_CTRL_OC_EN] && oc_s;
    wire oc_hit = oc_cond && (oc_cnt_ff == OC_LEN - 16'd1);
    wire [15:0] nxt_oc_cnt = !oc_cond ? 16'd0 : (oc_hit ? oc_cnt_ff : oc_cnt_ff + 16'd1);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uv_cnt_ff <= 16'd0;
            oc_cnt_ff <= 16'd0;
        end else begin
            uv_cnt_ff <= nxt_uv_cnt;
            oc_cnt_ff <= nxt_oc_cnt;
        end
    end

    // ----------------------------------------
    // fault and thermal latches
    // ----------------------------------------
    wire en_rise = en_s && !en_d_ff;
    wire seq_rise = seq_s && !seq_d_ff;
    wire fault_set = uv_hit || oc_hit;
    // clear only once nothing is still pending
    wire fault_clr = (en_rise || seq_rise) && !oc_s && !uv_cond;
    wire nxt_fault = fault_set || (fault_ff && !fault_clr);
    // nothing but reset clears it
    wire nxt_therm = therm_ff || ot_s;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_ff <= 1'b0;
            therm_ff <= 1'b0;
            en_d_ff <= 1'b0;
            seq_d_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
            therm_ff <= nxt_therm;
            en_d_ff <= en_s;
            seq_d_ff <= seq_s;
        end
    end

    // ----------------------------------------
    // supervisor reset output
    // ----------------------------------------
    localparam logic [15:0] RST_LEN = 16'(RST_TICKS);

    wire rst_hold = !mon_s || !en_s || fault_ff || therm_ff;
    wire rst_full = sw_tick_ff && (rst_cnt_ff == RST_LEN - 16'd1);
    sss_pkg::sss_rst_state_t nxt_rst_st;
    logic [15:0] nxt_rst_cnt;

    always_comb begin
        nxt_rst_st = rst_st_ff;
        nxt_rst_cnt = rst_cnt_ff;
        case (rst_st_ff)
            sss_pkg::SSS_RS_HOLD: begin
                nxt_rst_cnt = 16'd0;
                if (!rst_hold) begin
                    nxt_rst_st = sss_pkg::SSS_RS_TIME;
                end
            end
            sss_pkg::SSS_RS_TIME: begin
                if (rst_hold) begin
                    nxt_rst_st = sss_pkg::SSS_RS_HOLD;
                    nxt_rst_cnt = 16'd0;
                end else if (rst_full) begin
                    nxt_rst_st = sss_pkg::SSS_RS_OPEN;
                end else begin
                    nxt_rst_cnt = rst_cnt_ff + 16'(sw_tick_ff);
                end
            end
            sss_pkg::SSS_RS_OPEN: begin
                if (rst_hold) begin
                    nxt_rst_st = sss_pkg::SSS_RS_HOLD;
                    nxt_rst_cnt = 16'd0;
                end
            end
            default: begin
                nxt_rst_st = sss_pkg::SSS_RS_HOLD;
                nxt_rst_cnt = 16'd0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_st_ff <= sss_pkg::SSS_RS_HOLD;
            rst_cnt_ff <= 16'd0;
            rst_oe_b_ff <= 1'b0;
        end else begin
            rst_st_ff <= nxt_rst_st;
            rst_cnt_ff <= nxt_rst_cnt;
            rst_oe_b_ff <= (nxt_rst_st == sss_pkg::SSS_RS_OPEN);
        end
    end

    // pin state is an output only; only the status register samples it
    assign sup_rst_o = 1'b0;
    assign sup_rst_oe_b_o = rst_oe_b_ff;

    // ----------------------------------------
    // valley current limit
    // ----------------------------------------
    // threshold itself is analog, set by valley_limit_setting
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hs_inh_ff <= 1'b0;
        end else begin
            hs_inh_ff <= ls_s && valley_s;
        end
    end

    assign hs_inhibit_o = hs_inh_ff;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire acc = psel_i && penable_i;
    wire hit_ctrl = (paddr_i == `SSS_OFS_CTRL);
    wire hit_stat = (paddr_i == `SSS_OFS_STAT);
    wire hit_lo = (paddr_i == `SSS_OFS_REF_LO);
    wire hit_hi = (paddr_i == `SSS_OFS_REF_HI);
    wire hit_any = hit_ctrl || hit_stat || hit_lo || hit_hi;
    wire wr_ctrl = acc && pwrite_i && hit_ctrl;

    wire [31:0] stat_word = {10'h000, reg_done, 2'h0, reg_run, 3'h0, buck_run, rate_s,
                             rst_oe_b_ff, therm_ff, fault_ff};
    wire [31:0] lo_word = {2'h0, ss_code_o[23:18], 2'h0, ss_code_o[17:12],
                           2'h0, ss_code_o[11:6], 2'h0, ss_code_o[5:0]};
    wire [31:0] hi_word = {16'h0000, 2'h0, ss_code_o[35:30], 2'h0, ss_code_o[29:24]};
    wire [31:0] rd_word = hit_ctrl ? ctrl_ff :
                          hit_stat ? stat_word :
                          hit_lo ? lo_word :
                          hit_hi ? hi_word : 32'h0000_0000;
    wire [31:0] nxt_ctrl = wr_ctrl ? {30'h0, pwdata_i[1:0]} : ctrl_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= `SSS_CTRL_RST;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            prdata_ff <= (psel_i && !penable_i && !pwrite_i) ? rd_word : prdata_ff;
            pslverr_ff <= (psel_i && !penable_i) ? !hit_any : pslverr_ff;
        end
    end

    // setup cycle captures the answer, access phase completes at once
    assign pready_o = 1'b1;
    assign prdata_o = prdata_ff;
    assign pslverr_o = pslverr_ff && acc;
endmodule : sss_top

// File: tb/sss_plant_model.sv
module sss_plant_model (
    input wire logic clk_sys_i, // clock
    input wire logic buck_en_i, // buck enable
    input wire logic [4:0] lr_en_i, // lr1..lr5 enables
    input wire logic onl_source_i, // on-pin sources
    input wire logic sup_rst_i, // reset level
    input wire logic sup_rst_oe_b_i, // reset enable, low drives
    output logic [5:0] out_low_o, // below 90%
    output logic [3:0] onl_reached_o, // on thresholds
    output logic mon_good_o, // monitor above trip
    output logic rst_pin_o // reset wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // power stages and processor side
    // ----------------------------------------
    // a stage that is off sits below target, so it reads low
    assign out_low_o = ~{lr_en_i, buck_en_i};
    assign mon_good_o = buck_en_i;
    // pull-up holds the wire high once released
    assign rst_pin_o = sup_rst_oe_b_i ? 1'b1 : sup_rst_i;
    initial onl_reached_o = 4'h0;
    always @(posedge clk_sys_i) onl_reached_o <= {4{onl_source_i}};
endmodule : sss_plant_model

// File: tb/sss_top_monitor.sv
module sss_chk #(
    parameter int RST_TICKS = 512
) (
    input wire logic clk_sys_i, // clock
    input wire logic rst_b_i, // reset, active low
    input wire logic en_i, // enable
    input wire logic reset_monitor_input_i, // monitor
    input wire logic over_temp_i, // thermal
    input wire logic ls_conduct_i, // low side on
    input wire logic valley_trip_i, // valley trip
    input wire logic buck_en_o, // buck enable
    input wire logic internal_logic_supply_en_o, // logic supply
    input wire logic [35:0] ss_code_o, // ramp codes
    input wire logic hs_inhibit_o, // inhibit
    input wire logic sup_rst_oe_b_o // reset pin enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [31:0] good_ff;
    logic [31:0] gap_ff;
    logic [5:0] last_ff;
    wire logic [5:0] buck_c = ss_code_o[5:0];
    wire logic [5:0] neg_c = ss_code_o[35:30];
    // the raw good time is an upper bound, the synchroniser only adds delay
    wire logic ok_in = reset_monitor_input_i && en_i && !over_temp_i;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            good_ff <= 32'h0;
            gap_ff <= 32'h0;
            last_ff <= 6'h00;
        end else begin
            good_ff <= ok_in ? good_ff + 32'h1 : 32'h0;
            gap_ff <= (buck_c != last_ff) ? 32'h0 : gap_ff + 32'h1;
            last_ff <= buck_c;
        end
    end
    a_therm_off: assert property (over_temp_i [*8] |-> !internal_logic_supply_en_o)
        else $error("logic supply stays on while hot");
    a_en_off: assert property (!en_i [*6] |-> !buck_en_o)
        else $error("buck runs with enable low");
    a_rst_en: assert property (!en_i [*8] |-> !sup_rst_oe_b_o)
        else $error("reset released with enable low");
    a_rst_mon: assert property (!reset_monitor_input_i [*8] |-> !sup_rst_oe_b_o)
        else $error("reset released with monitor low");
    a_rst_wait: assert property ($rose(sup_rst_oe_b_o) |-> good_ff >= (RST_TICKS - 1) * 500)
        else $error("reset released before timeout");
    a_hs_block: assert property ((ls_conduct_i && valley_trip_i) [*7] |-> hs_inhibit_o)
        else $error("high side not blocked");
    a_hs_free: assert property (!valley_trip_i [*7] |-> !hs_inhibit_o)
        else $error("high side blocked without trip");
    a_code_up: assert property ($changed(buck_c) |-> buck_c == $past(buck_c) + 6'h01 || buck_c == 6'h00)
        else $error("buck code jumped");
    a_code_down: assert property ($changed(neg_c) |-> neg_c == $past(neg_c) - 6'h01 || neg_c == 6'h20)
        else $error("negative code jumped");
    a_step_gap: assert property (buck_c != last_ff && buck_c != 6'h00 |-> gap_ff >= 32'd15500)
        else $error("ramp step too early");
endmodule : sss_chk

bind sss_top sss_chk #(.RST_TICKS(RST_TICKS)) chk_u (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .en_i(en_i), .reset_monitor_input_i(reset_monitor_input_i),
    .over_temp_i(over_temp_i), .ls_conduct_i(ls_conduct_i), .valley_trip_i(valley_trip_i),
    .buck_en_o(buck_en_o), .internal_logic_supply_en_o(internal_logic_supply_en_o),
    .ss_code_o(ss_code_o), .hs_inhibit_o(hs_inhibit_o), .sup_rst_oe_b_o(sup_rst_oe_b_o)
);

// File: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam int RT = 4;
    localparam int OCF = 20;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err = 1'b0, win_ok = 1'b0;
    logic en = 1'b0, seq = 1'b0, rate = 1'b0, ot = 1'b0, oc = 1'b0, ls = 1'b0, vt = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, last_rd = 32'h0, rng = 32'h49;
    int fail_count = 0, checks_done = 0, cyc = 0;
    logic [35:0] exp_q[$];
    event chk_ev;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, buck_en, ilse, onl_src, hs, srst, srst_oe_b, mon, rpin;
    wire logic [4:0] lr_en;
    wire logic [5:0] out_low;
    wire logic [3:0] onl;
    wire logic [35:0] code;
    always #2 clk_sys_i = ~clk_sys_i;
    sss_top #(.FAULT_TICKS(4), .RST_TICKS(RT), .OC_FILT_CYC(OCF)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .en_i(en), .sequence_control_i(seq),
        .switching_rate_select_i(rate), .reset_monitor_input_i(mon), .over_temp_i(ot),
        .over_current_i(oc), .out_low_i(out_low), .onl_reached_i(onl), .ls_conduct_i(ls),
        .valley_trip_i(vt), .buck_en_o(buck_en), .linear_regulator_channel_en_o(lr_en),
        .internal_logic_supply_en_o(ilse), .onl_source_o(onl_src), .ss_code_o(code),
        .hs_inhibit_o(hs), .sup_rst_o(srst), .sup_rst_oe_b_o(srst_oe_b)
    );
    sss_plant_model plant_u (
        .clk_sys_i(clk_sys_i), .buck_en_i(buck_en), .lr_en_i(lr_en), .onl_source_i(onl_src),
        .sup_rst_i(srst), .sup_rst_oe_b_i(srst_oe_b), .out_low_o(out_low), .onl_reached_o(onl),
        .mon_good_o(mon), .rst_pin_o(rpin)
    );
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [31:0] pick(input logic [3:0] id);
        case (id)
            4'h0: return {30'h0, last_rd[1:0]};
            4'h1: return {31'h0, last_err};
            4'h2: return {31'h0, buck_en};
            4'h3: return {31'h0, rpin};
            4'h4: return {31'h0, ilse};
            4'h5: return {26'h0, code[5:0]};
            4'h6: return {31'h0, hs};
            4'h7: return {31'h0, last_rd[3]};
            default: return {31'h0, win_ok};
        endcase
    endfunction : pick
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    // notes go in the queue; the watcher samples once the outputs settle
    task automatic chk(input logic [3:0] id, input logic [31:0] e);
        exp_q.push_back({id, e});
        @(negedge clk_sys_i);
        -> chk_ev;
        @(posedge clk_sys_i);
    endtask : chk
    task automatic wait_for(input logic [3:0] id, input logic [31:0] e, input int lim);
        int n;
        n = 0;
        while (pick(id) !== e && n < lim) begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask : wait_for
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        last_rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    always @(chk_ev) begin
        logic [35:0] nt;
        while (exp_q.size() > 0) begin
            nt = exp_q.pop_front();
            checks_done++;
            if (pick(nt[35:32]) !== nt[31:0]) begin
                fail_count++;
                $display("MISMATCH item %0d expected %h seen %h", nt[35:32], nt[31:0], pick(nt[35:32]));
            end
        end
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [31:0] wd;
        int k;
        int t0;
        tick(4);
        rst_b_i <= 1'b1;
        tick(6);
        chk(4'h4, 32'h1);
        chk(4'h3, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(4'h0, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk(4'h1, 32'h1);
        rng = xs(rng);
        wd = rng;
        apb(1'b1, 12'h000, wd);
        apb(1'b0, 12'h000, 32'h0);
        chk(4'h0, {30'h0, wd[1:0]});
        apb(1'b1, 12'h000, 32'h3);
        for (k = 0; k < 2; k++) begin
            rate <= k[0];
            tick(6);
            apb(1'b0, 12'h004, 32'h0);
            chk(4'h7, {31'h0, k[0]});
        end
        en <= 1'b1;
        seq <= 1'b1;
        t0 = cyc;
        tick(10);
        chk(4'h2, 32'h1);
        wait_for(4'h3, 32'h1, 5000);
        win_ok = (cyc - t0) >= (RT - 1) * 500;
        chk(4'h8, 32'h1);
        chk(4'h3, 32'h1);
        wait_for(4'h5, 32'h1, 40000);
        win_ok = (cyc - t0) >= 31500 && (cyc - t0) <= 32600;
        chk(4'h8, 32'h1);
        chk(4'h5, 32'h1);
        rng = xs(rng);
        oc <= 1'b1;
        tick(1 + int'(rng[3:0]));
        oc <= 1'b0;
        tick(30);
        chk(4'h2, 32'h1);
        for (k = 0; k < 2; k++) begin
            oc <= 1'b1;
            tick(OCF + 20);
            chk(4'h2, 32'h0);
            chk(4'h3, 32'h0);
            chk(4'h4, 32'h1);
            oc <= 1'b0;
            tick(8);
            en <= (k == 0) ? 1'b0 : 1'b1;
            seq <= (k == 0) ? 1'b1 : 1'b0;
            tick(8);
            en <= 1'b1;
            seq <= 1'b1;
            tick(10);
            chk(4'h2, 32'h1);
            chk(4'h5, 32'h0);
        end
        ls <= 1'b1;
        vt <= 1'b1;
        tick(8);
        chk(4'h6, 32'h1);
        vt <= 1'b0;
        tick(8);
        chk(4'h6, 32'h0);
        ls <= 1'b0;
        ot <= 1'b1;
        tick(10);
        chk(4'h4, 32'h0);
        chk(4'h2, 32'h0);
        ot <= 1'b0;
        en <= 1'b0;
        tick(8);
        en <= 1'b1;
        tick(10);
        chk(4'h4, 32'h0);
        rst_b_i <= 1'b0;
        tick(4);
        rst_b_i <= 1'b1;
        tick(10);
        chk(4'h4, 32'h1);
        chk(4'h2, 32'h1);
        report_and_stop();
    end
endmodule : tb_top
